// File: rtl/rx_steer_consts.vh
// constants for the receive-buffer steering block
`ifndef RX_STEER_CONSTS_VH
`define RX_STEER_CONSTS_VH
// register offsets
`define OFS_FULL_PIN_CTRL   8'h0E
`define OFS_IRQ_FLAGS       8'h2C
`define OFS_RX_HI_CTRL      8'h60
`define OFS_RX_LO_CTRL      8'h70
// assembly buffer / receive buffer length in bytes
`define MAB_LEN             13
`define MAB_IDX_W           4
// control register fields
`define CTL_MODE_HI         6
`define CTL_MODE_LO         5
`define CTL_RTR             3
`define CTL_ROLL            2
`define CTL_ROLL_COPY       1
`define CTL_HIT0            0
// full pin control fields
`define FPC_HI_IRQ          0
`define FPC_LO_IRQ          1
`define FPC_HI_EN           2
`define FPC_LO_EN           3
`define FPC_HI_LVL          4
`define FPC_LO_LVL          5
// irq flag fields
`define IFL_HI_LOADED       0
`define IFL_LO_LOADED       1
// receive modes
`define MODE_FILTERED       2'h0
`define MODE_STD_ONLY       2'h1
`define MODE_EXT_ONLY       2'h2
`define MODE_ALL            2'h3
// reset values
`define RST_CTRL            8'h00
`define RST_FPC             8'h00
// fifo shape
`define FIFO_WIDTH          10
`define FIFO_DEPTH          16
`define FIFO_AW             4
`endif

// File: rtl/frame_fifo.v
// small synchronous fifo between link capture and buffer steering
`default_nettype none
module frame_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             ref_clk,
    input  wire             resetn,
    input  wire             ce,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_r;
    reg [AW-1:0]    rd_ptr_r;
    reg [AW:0]      count_r;
    wire            push;
    wire            pop;

    localparam [AW:0]   DEPTH_C = DEPTH;
    localparam [AW:0]   ONE_C   = 1;
    localparam [AW-1:0] STEP_C  = 1;

    assign in_ready  = (count_r != DEPTH_C);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rd_ptr_r];

    always @(posedge ref_clk) begin
        if (ce && push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + STEP_C;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + STEP_C;
            end
            if (push && !pop) begin
                count_r <= count_r + ONE_C;
            end else if (pop && !push) begin
                count_r <= count_r - ONE_C;
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/can_rx_buffer_steering.v
// receive-buffer steering: priority, rollover, modes and full pins
// What this block does
// RL1: high buffer has filters 0-1, low buffer 2-5; high buffer is tried first.
// RL2: rollover on, high buffer loaded and low buffer free: message goes low, no overflow.
// RL3: storing a message updates filter number and remote flag bits 3:0.
// RL4: mode 00 accepts valid messages passing filters; filter picks id type.
// RL5: mode 01 standard only, 10 extended only; mismatched filter never hits.
// RL6: mode 11 takes every message regardless of filter values.
// RL7: mode 11 also loads the assembled part of an errored frame.
// RL8: first full pin serves high buffer, second serves low buffer.
// RL9: enable and irq select set: pin low while loaded flag set.
// RL10: irq select 0, enable 1: pin follows its level bit.
// RL11: host changes pin level only by bit-modify writes, avoiding glitches.
// RL12: bits 7 and 4 of high control ignore writes, read zero.
// RL13: loaded flag set on store; buffer locked until host clears it.
// RL14: acceptance copies whole assembly buffer over the target buffer.
// RL15: high filter-hit bit 0/1 for filter 0/1, kept through rollover.
`include "rx_steer_consts.vh"
`default_nettype none
module can_rx_buffer_steering (
    input  wire       ref_clk,
    input  wire       resetn,
    input  wire       ce,
    input  wire       link_clk,
    input  wire       link_valid,
    input  wire [7:0] link_data,
    input  wire       link_last,
    input  wire       link_err,
    output wire       link_ready,
    input  wire [5:0] filter_ext_id_select,
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_mask,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata_r,
    output reg        rx_hi_full_pin,
    output reg        rx_hi_full_pin_oe,
    output reg        rx_lo_full_pin,
    output reg        rx_lo_full_pin_oe,
    output reg        rx_overflow_r
);
    localparam [1:0] ST_HEAD   = 2'h0;
    localparam [1:0] ST_BODY   = 2'h1;
    localparam [1:0] ST_COMMIT = 2'h2;
    localparam [`MAB_IDX_W-1:0] IDX_ONE = 1;
    localparam [`MAB_IDX_W-1:0] IDX_MAX = `MAB_LEN;
    localparam [7:0] RST_CTRL_C = `RST_CTRL;

    // link pins come from another clock: two stages before any use
    reg  [11:0] sync1_r;
    reg  [11:0] sync2_r;
    reg         clk_prev_r;
    wire        link_rise;
    wire        fifo_out_valid;
    wire        fifo_out_ready;
    wire [9:0]  fifo_out_data;

    reg  [1:0]  state_r;
    reg  [7:0]  head_r;
    reg         frame_err_r;
    reg  [`MAB_IDX_W-1:0] idx_r;
    reg  [7:0]  mab_r    [0:`MAB_LEN-1];
    reg  [7:0]  buf_hi_r [0:`MAB_LEN-1];
    reg  [7:0]  buf_lo_r [0:`MAB_LEN-1];

    reg  [1:0]  hi_mode_r;
    reg         hi_rtr_r;
    reg         rollover_enable_r;
    reg         hi_hit_r;
    reg  [1:0]  lo_mode_r;
    reg         lo_rtr_r;
    reg  [2:0]  lo_hit_r;
    reg  [7:0]  full_pin_control_r;
    reg         hi_loaded_r;
    reg         lo_loaded_r;

    integer     i;

    // filter hits that survive the buffer's receive mode
    function [5:0] mode_hits;
        input [1:0] mode;
        input [5:0] match;
        input [5:0] sel;
        input       ext;
        begin
            case (mode)
                `MODE_FILTERED: mode_hits = match; // RL4
                `MODE_STD_ONLY: mode_hits = match & ~sel & {6{~ext}}; // RL5
                `MODE_EXT_ONLY: mode_hits = match & sel & {6{ext}}; // RL5
                default:        mode_hits = match;
            endcase
        end
    endfunction

    function [7:0] bit_modify;
        input [7:0] old;
        input [7:0] wd;
        input [7:0] mask;
        begin
            bit_modify = (old & ~mask) | (wd & mask);
        end
    endfunction

    // header: [5:0] raw filter matches, [6] extended id, [7] remote
    wire [5:0] hits_hi  = mode_hits(hi_mode_r, head_r[5:0],
                                    filter_ext_id_select, head_r[6]);
    wire [5:0] hits_lo  = mode_hits(lo_mode_r, head_r[5:0],
                                    filter_ext_id_select, head_r[6]);
    wire       all_hi   = (hi_mode_r == `MODE_ALL);
    wire       all_lo   = (lo_mode_r == `MODE_ALL);
    // errored frames reach a buffer only in receive-everything mode
    wire       hi_ok    = (all_hi || (!frame_err_r && |hits_hi[1:0])); // RL6 RL7
    wire       lo_ok    = (all_lo || (!frame_err_r && |hits_lo[5:2])); // RL6 RL7
    wire       hi_hit_n = !hits_hi[0] && hits_hi[1]; // RL15
    wire [2:0] lo_hit_n = hits_lo[2] ? 3'h2 : hits_lo[3] ? 3'h3 :
                          hits_lo[4] ? 3'h4 : hits_lo[5] ? 3'h5 : 3'h2;
    wire       commit   = (state_r == ST_COMMIT);
    wire       to_hi    = commit && hi_ok && !hi_loaded_r; // RL1 RL13
    wire       roll     = commit && hi_ok && hi_loaded_r &&
                          rollover_enable_r && !lo_loaded_r; // RL2
    wire       to_lo_f  = commit && !hi_ok && lo_ok && !lo_loaded_r; // RL1
    wire       to_lo    = roll || to_lo_f;
    wire       ovf      = commit && !to_hi && !to_lo &&
                          ((hi_ok && !(hi_loaded_r && rollover_enable_r))
                           || lo_ok || roll);
    wire       wr_hi_c  = reg_wr && (reg_addr == `OFS_RX_HI_CTRL);
    wire       wr_lo_c  = reg_wr && (reg_addr == `OFS_RX_LO_CTRL);
    wire       wr_fpc   = reg_wr && (reg_addr == `OFS_FULL_PIN_CTRL);
    wire       wr_ifl   = reg_wr && (reg_addr == `OFS_IRQ_FLAGS);
    wire [7:0] hi_ctrl  = {1'b0, hi_mode_r, 1'b0, hi_rtr_r,
                           rollover_enable_r, rollover_enable_r,
                           hi_hit_r}; // RL12
    wire [7:0] lo_ctrl  = {1'b0, lo_mode_r, 1'b0, lo_rtr_r, lo_hit_r};
    wire [7:0] ifl      = {6'h00, lo_loaded_r, hi_loaded_r};
    wire [7:0] hi_wv    = bit_modify(hi_ctrl, reg_wdata, reg_mask);
    wire [7:0] lo_wv    = bit_modify(lo_ctrl, reg_wdata, reg_mask);
    wire [7:0] ifl_wv   = bit_modify(ifl, reg_wdata, reg_mask);
    wire [7:0] fpc_wv   = bit_modify(full_pin_control_r, reg_wdata, reg_mask);

    assign link_rise      = sync2_r[11] && !clk_prev_r;
    // drain stalls while a frame is being copied into a buffer
    assign fifo_out_ready = !commit;

    frame_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .ce        (ce),
        .in_valid  (link_rise && sync2_r[10]),
        .in_ready  (link_ready),
        .in_data   (sync2_r[9:0]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    always @(posedge ref_clk) begin
        if (!resetn) begin
            sync1_r    <= 12'h000;
            sync2_r    <= 12'h000;
            clk_prev_r <= 1'b0;
        end else if (ce) begin
            sync1_r    <= {link_clk, link_valid, link_err, link_last,
                           link_data};
            sync2_r    <= sync1_r;
            clk_prev_r <= sync2_r[11];
        end
    end

    // assembly: header, then body bytes until an entry marked last
    always @(posedge ref_clk) begin
        if (!resetn) begin
            state_r     <= ST_HEAD;
            head_r      <= 8'h00;
            frame_err_r <= 1'b0;
            idx_r       <= {`MAB_IDX_W{1'b0}};
        end else if (ce) begin
            case (state_r)
                ST_HEAD: begin
                    if (fifo_out_valid) begin
                        head_r      <= fifo_out_data[7:0];
                        frame_err_r <= fifo_out_data[9];
                        idx_r       <= {`MAB_IDX_W{1'b0}};
                        state_r     <= fifo_out_data[8] ? ST_COMMIT
                                                        : ST_BODY;
                    end
                end
                ST_BODY: begin
                    if (fifo_out_valid) begin
                        if (idx_r != IDX_MAX) begin
                            idx_r <= idx_r + IDX_ONE;
                        end
                        frame_err_r <= fifo_out_data[9];
                        if (fifo_out_data[8]) begin
                            state_r <= ST_COMMIT;
                        end
                    end
                end
                ST_COMMIT: begin
                    state_r <= ST_HEAD;
                end
                default: begin
                    state_r <= ST_HEAD;
                end
            endcase
        end
    end

    // bytes never assembled read zero once copied
    always @(posedge ref_clk) begin
        if (!resetn) begin
            for (i = 0; i < `MAB_LEN; i = i + 1) begin
                mab_r[i]    <= 8'h00;
                buf_hi_r[i] <= 8'h00;
                buf_lo_r[i] <= 8'h00;
            end
        end else if (ce) begin
            for (i = 0; i < `MAB_LEN; i = i + 1) begin
                if (state_r == ST_HEAD && fifo_out_valid) begin
                    mab_r[i] <= 8'h00;
                end else if (state_r == ST_BODY && fifo_out_valid &&
                             idx_r == i[`MAB_IDX_W-1:0]) begin
                    mab_r[i] <= fifo_out_data[7:0];
                end
                if (to_hi) begin
                    buf_hi_r[i] <= mab_r[i]; // RL14
                end
                if (to_lo) begin
                    buf_lo_r[i] <= mab_r[i]; // RL14
                end
            end
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            hi_mode_r          <= RST_CTRL_C[`CTL_MODE_HI:`CTL_MODE_LO];
            hi_rtr_r           <= 1'b0;
            rollover_enable_r  <= 1'b0;
            hi_hit_r           <= 1'b0;
            lo_mode_r          <= RST_CTRL_C[`CTL_MODE_HI:`CTL_MODE_LO];
            lo_rtr_r           <= 1'b0;
            lo_hit_r           <= 3'h0;
            full_pin_control_r <= `RST_FPC;
            hi_loaded_r        <= 1'b0;
            lo_loaded_r        <= 1'b0;
            rx_overflow_r      <= 1'b0;
        end else if (ce) begin
            if (wr_hi_c) begin
                hi_mode_r         <= hi_wv[`CTL_MODE_HI:`CTL_MODE_LO];
                rollover_enable_r <= hi_wv[`CTL_ROLL];
            end
            if (wr_lo_c) begin
                lo_mode_r <= lo_wv[`CTL_MODE_HI:`CTL_MODE_LO];
            end
            if (wr_fpc) begin
                full_pin_control_r <= {2'h0, fpc_wv[5:0]}; // RL11
            end
            if (to_hi) begin
                hi_rtr_r <= head_r[7]; // RL3
                hi_hit_r <= hi_hit_n; // RL3 RL15
            end
            if (to_lo) begin
                lo_rtr_r <= head_r[7]; // RL3
                // rolled message keeps its high filter number
                lo_hit_r <= roll ? {2'h0, hi_hit_n} : lo_hit_n; // RL2 RL15
            end
            // a store in the clearing cycle keeps the flag set
            hi_loaded_r <= to_hi ||
                           (wr_ifl ? ifl_wv[`IFL_HI_LOADED]
                                   : hi_loaded_r); // RL13
            lo_loaded_r <= to_lo ||
                           (wr_ifl ? ifl_wv[`IFL_LO_LOADED]
                                   : lo_loaded_r); // RL13
            rx_overflow_r <= ovf;
        end
    end

    // read data follows the address one cycle later
    always @(posedge ref_clk) begin
        if (!resetn) begin
            reg_rdata_r <= 8'h00;
        end else if (ce) begin
            if (reg_addr == `OFS_RX_HI_CTRL) begin
                reg_rdata_r <= hi_ctrl; // RL12
            end else if (reg_addr == `OFS_RX_LO_CTRL) begin
                reg_rdata_r <= lo_ctrl;
            end else if (reg_addr == `OFS_FULL_PIN_CTRL) begin
                reg_rdata_r <= full_pin_control_r;
            end else if (reg_addr == `OFS_IRQ_FLAGS) begin
                reg_rdata_r <= ifl;
            end else if (reg_addr > `OFS_RX_HI_CTRL &&
                         reg_addr <= `OFS_RX_HI_CTRL + `MAB_LEN) begin
                reg_rdata_r <= buf_hi_r[reg_addr - `OFS_RX_HI_CTRL - 1];
            end else if (reg_addr > `OFS_RX_LO_CTRL &&
                         reg_addr <= `OFS_RX_LO_CTRL + `MAB_LEN) begin
                reg_rdata_r <= buf_lo_r[reg_addr - `OFS_RX_LO_CTRL - 1];
            end else begin
                reg_rdata_r <= 8'h00;
            end
        end
    end

    // disabled pins float high through oe low
    always @(posedge ref_clk) begin
        if (!resetn) begin
            rx_hi_full_pin    <= 1'b1;
            rx_hi_full_pin_oe <= 1'b0;
            rx_lo_full_pin    <= 1'b1;
            rx_lo_full_pin_oe <= 1'b0;
        end else if (ce) begin
            rx_hi_full_pin_oe <= full_pin_control_r[`FPC_HI_EN]; // RL8
            rx_lo_full_pin_oe <= full_pin_control_r[`FPC_LO_EN]; // RL8
            if (!full_pin_control_r[`FPC_HI_EN]) begin
                rx_hi_full_pin <= 1'b1;
            end else if (full_pin_control_r[`FPC_HI_IRQ]) begin
                rx_hi_full_pin <= !hi_loaded_r; // RL9
            end else begin
                rx_hi_full_pin <= full_pin_control_r[`FPC_HI_LVL]; // RL10
            end
            if (!full_pin_control_r[`FPC_LO_EN]) begin
                rx_lo_full_pin <= 1'b1;
            end else if (full_pin_control_r[`FPC_LO_IRQ]) begin
                rx_lo_full_pin <= !lo_loaded_r; // RL9
            end else begin
                rx_lo_full_pin <= full_pin_control_r[`FPC_LO_LVL]; // RL10
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/can_rx_buffer_steering_assertions.sv
// port checker for the receive-buffer steering block
`default_nettype none
module can_rx_buffer_steering_assertions (
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic       ce,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_mask,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_r,
    input wire logic       rx_hi_full_pin,
    input wire logic       rx_hi_full_pin_oe,
    input wire logic       rx_lo_full_pin,
    input wire logic       rx_lo_full_pin_oe,
    input wire logic       rx_overflow_r
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // shadow of the pin control register, kept from bus writes alone
    logic [7:0] fpc_s;
    always_ff @(posedge ref_clk) begin
        if (!resetn)
            fpc_s <= 8'h00;
        else if (ce && reg_wr && reg_addr == 8'h0E)
            fpc_s <= (fpc_s & ~reg_mask) | (reg_wdata & reg_mask);
    end
    a_hi_plain_out: assert property (
        fpc_s[2] && !fpc_s[0] |=> rx_hi_full_pin_oe
        && rx_hi_full_pin == $past(fpc_s[4]))
        else $error("hi pin not following its level bit");
    a_lo_plain_out: assert property (
        fpc_s[3] && !fpc_s[1] |=> rx_lo_full_pin_oe
        && rx_lo_full_pin == $past(fpc_s[5]))
        else $error("lo pin not following its level bit");
    a_pins_released: assert property (
        !fpc_s[2] && !fpc_s[3] |=> !rx_hi_full_pin_oe
        && !rx_lo_full_pin_oe)
        else $error("disabled pin still driven");
    a_irq_pins_driven: assert property (
        fpc_s[2] && fpc_s[0] && fpc_s[3] && fpc_s[1]
        |=> rx_hi_full_pin_oe && rx_lo_full_pin_oe)
        else $error("interrupt-mode pin not driven");
    a_unused_bits_zero: assert property (
        reg_addr == 8'h60 || reg_addr == 8'h70
        |=> reg_rdata_r[7] == 1'b0 && reg_rdata_r[4] == 1'b0)
        else $error("unimplemented control bit reads one");
    a_unmapped_zero: assert property (
        reg_addr == 8'h0F |=> reg_rdata_r == 8'h00)
        else $error("unmapped address reads nonzero");
    a_fpc_readback: assert property (
        reg_addr == 8'h0E && !reg_wr
        |=> reg_rdata_r == {2'b00, $past(fpc_s[5:0])})
        else $error("pin control readback wrong");
    a_ovf_one_cycle: assert property (
        rx_overflow_r |=> !rx_overflow_r)
        else $error("overflow pulse longer than one cycle");
    a_reset_values: assert property (disable iff (1'b0)
        !resetn |=> reg_rdata_r == 8'h00 && rx_hi_full_pin
        && rx_lo_full_pin && !rx_hi_full_pin_oe && !rx_overflow_r)
        else $error("reset values wrong");
endmodule
bind can_rx_buffer_steering can_rx_buffer_steering_assertions u_chk (
    .ref_clk, .resetn, .ce, .reg_addr, .reg_wr, .reg_mask, .reg_wdata,
    .reg_rdata_r, .rx_hi_full_pin, .rx_hi_full_pin_oe, .rx_lo_full_pin,
    .rx_lo_full_pin_oe, .rx_overflow_r);
`default_nettype wire

// File: bench/link_engine.sv
// protocol-engine model feeding assembled frames over the link
`default_nettype none
module link_engine (
    output logic       link_clk,
    output logic       link_valid,
    output logic [7:0] link_data,
    output logic       link_last,
    output logic       link_err,
    input  wire logic  link_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        link_clk = 0;
        link_valid = 0;
        link_data = 8'h00;
        link_last = 0;
        link_err = 0;
    end
    // link clock only runs inside a frame; body byte k is A0+k
    task automatic send(input logic [7:0] hdr, input int n, input bit err);
        for (int k = 0; k <= n; k++) begin
            link_data = (k == 0) ? hdr : 8'h9F + 8'(k);
            link_valid = 1;
            link_last = (k == n);
            link_err = err && (k == n);
            // never push into a full fifo
            while (link_ready !== 1'b1)
                #100;
            #100 link_clk = 1;
            #100 link_clk = 0;
        end
        link_valid = 0;
        link_last = 0;
        link_err = 0;
        link_data = ~link_data;
    endtask
endmodule
`default_nettype wire

// File: bench/can_rx_buffer_steering_tb.sv
// self-checking bench for the receive-buffer steering block
`default_nettype none
module can_rx_buffer_steering_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       ref_clk = 0;
    logic       resetn = 0;
    logic       link_clk, link_valid, link_last, link_err, link_ready;
    logic [7:0] link_data;
    logic [7:0] reg_addr = 0, reg_mask = 0, reg_wdata = 0, rd, b, n0;
    logic [7:0] reg_rdata_r, ovf_n = 0;
    logic [5:0] fsel = 0;
    logic       reg_wr = 0;
    logic       hp, hoe, lp, loe, ovf;
    int         mismatches = 0;
    int         cmp_count = 0;
    typedef struct {
        logic [7:0] hc, lc, hdr;
        logic [5:0] fs;
        bit         err;
        logic [1:0] ef;
        logic [7:0] ec;
    } row_t;
    // hi ctrl, lo ctrl, header, ext selects, error, flags, target ctrl
    row_t rows[10] = '{
        '{8'h00, 8'h00, 8'h02, 6'h00, 0, 2'h1, 8'h01},
        '{8'h00, 8'h00, 8'h88, 6'h00, 0, 2'h2, 8'h0B},
        '{8'h20, 8'h00, 8'h01, 6'h01, 0, 2'h0, 8'h00},
        '{8'h20, 8'h00, 8'h02, 6'h00, 0, 2'h1, 8'h21},
        '{8'h40, 8'h00, 8'h42, 6'h02, 0, 2'h1, 8'h41},
        '{8'h00, 8'h40, 8'h44, 6'h04, 0, 2'h2, 8'h42},
        '{8'h60, 8'h00, 8'h00, 6'h00, 0, 2'h1, 8'h60},
        '{8'h60, 8'h00, 8'h80, 6'h00, 1, 2'h1, 8'h68},
        '{8'h00, 8'h00, 8'h01, 6'h00, 1, 2'h0, 8'h00},
        '{8'h00, 8'h60, 8'h00, 6'h00, 0, 2'h2, 8'h62}};

    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (ovf === 1'b1)
            ovf_n <= ovf_n + 8'h01;

    link_engine u_link_engine (.link_clk, .link_valid, .link_data,
        .link_last, .link_err, .link_ready);
    can_rx_buffer_steering u_can_rx_buffer_steering (.ref_clk, .resetn,
        .ce(1'b1), .link_clk, .link_valid, .link_data, .link_last,
        .link_err, .link_ready, .filter_ext_id_select(fsel), .reg_addr,
        .reg_wr, .reg_mask, .reg_wdata, .reg_rdata_r,
        .rx_hi_full_pin(hp), .rx_hi_full_pin_oe(hoe),
        .rx_lo_full_pin(lp), .rx_lo_full_pin_oe(loe),
        .rx_overflow_r(ovf));

    task automatic cmp(input logic [7:0] g, e, input string m);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, m, d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_mask <= m;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge ref_clk) reg_wr <= 0;
    endtask
    task automatic chk(input logic [7:0] a, e, input string m);
        @(posedge ref_clk) reg_addr <= a;
        @(posedge ref_clk) #1 rd = reg_rdata_r;
        cmp(rd, e, m);
    endtask
    task automatic pins(input logic [7:0] e);
        repeat (2) @(posedge ref_clk);
        #1 cmp({4'h0, hp, hoe, lp, loe}, e, "pins");
    endtask
    // settle time covers sync, drain and commit of the last entry
    task automatic frame(input logic [7:0] hdr, input int n, input bit e);
        u_link_engine.send(hdr, n, e);
        repeat (60) @(posedge ref_clk);
    endtask
    task summarize;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #400000;
        mismatches++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1;
        chk(8'h60, 8'h00, "hi ctrl reset");
        chk(8'h0E, 8'h00, "pin ctrl reset");
        chk(8'h2C, 8'h00, "flags reset");
        pins(8'h0A);
        wr(8'h0F, 8'hFF, 8'h5A);
        chk(8'h0F, 8'h00, "unmapped");
        $display("reset test done");
        foreach (rows[i]) begin
            wr(8'h2C, 8'h03, 8'h00);
            wr(8'h60, 8'hFF, rows[i].hc);
            wr(8'h70, 8'hFF, rows[i].lc);
            fsel <= rows[i].fs;
            frame(rows[i].hdr, rows[i].err ? 3 : 13, rows[i].err);
            chk(8'h2C, {6'h00, rows[i].ef}, "flags");
            if (rows[i].ef != 2'h0) begin
                b = rows[i].ef[0] ? 8'h60 : 8'h70;
                chk(b, rows[i].ec, "ctrl");
                chk(b + 8'h01, 8'hA0, "byte 0");
                chk(b + 8'h04, rows[i].err ? 8'h00 : 8'hA3, "byte 3");
            end
            $display("row %0d done", i);
        end
        // rollover: second frame lands low, third finds both full
        wr(8'h2C, 8'h03, 8'h00);
        wr(8'h60, 8'hFF, 8'h04);
        wr(8'h70, 8'hFF, 8'h00);
        n0 = ovf_n;
        frame(8'h01, 13, 0);
        frame(8'h02, 13, 0);
        chk(8'h2C, 8'h03, "rollover flags");
        chk(8'h70, 8'h01, "rolled hit");
        cmp(ovf_n - n0, 8'h00, "rollover overflow");
        // both full with rollover on: message dropped, no overflow
        frame(8'h81, 13, 0);
        cmp(ovf_n - n0, 8'h00, "locked overflow");
        chk(8'h70, 8'h01, "lo ctrl kept");
        wr(8'h60, 8'hFF, 8'h00);
        frame(8'h02, 13, 0);
        cmp(ovf_n - n0, 8'h01, "hi overflow");
        wr(8'h60, 8'hFF, 8'hFF);
        chk(8'h60, 8'h66, "hi ctrl full write");
        $display("rollover test done");
        wr(8'h0E, 8'hFF, 8'h0F);
        pins(8'h05);
        wr(8'h2C, 8'h01, 8'h00);
        pins(8'h0D);
        wr(8'h0E, 8'hFF, 8'h1C);
        pins(8'h0D);
        wr(8'h0E, 8'h30, 8'h20);
        pins(8'h07);
        chk(8'h0E, 8'h2C, "pin ctrl modify");
        wr(8'h0E, 8'hFF, 8'h00);
        pins(8'h0A);
        $display("pin test done");
        summarize();
    end
endmodule
`default_nettype wire
